// *** inc/srsc_cfg.svh ***
// timing and encoding constants for the system reset source controller
`ifndef SRSC_CFG_SVH
`define SRSC_CFG_SVH
`define SRSC_CLK_MHZ         40
`define SRSC_TCL_PS          12500
`define SRSC_FILT_MIN_NS     50
`define SRSC_FILT_MAX_NS     500
`define SRSC_FILT_CYC        ((`SRSC_FILT_MIN_NS * `SRSC_CLK_MHZ + 999) / 1000)
`define SRSC_MIN4_TCL        4
`define SRSC_MAXPULSE_TCL    ((`SRSC_FILT_MAX_NS * 1000 + `SRSC_TCL_PS - 1) / `SRSC_TCL_PS)
`define SRSC_SEQ_TCL         (1032 + 12)
`define SRSC_EXT_REL_TCL     4
`define SRSC_FLASH_INIT_US   1000
`define SRSC_FLASH_INIT_CYC  (`SRSC_FLASH_INIT_US * `SRSC_CLK_MHZ)
`define SRSC_FLASH_FF_CYC    8
`define SRSC_CNT_W           16
`define SRSC_DATA_ERASED     16'hFFFF
`define SRSC_DATA_BUSY       16'h009B
`endif

// *** inc/srsc_pkg.sv ***
// types for the system reset source controller
package srsc_pkg;
    typedef enum logic [2:0] {
        SRSC_RUN    = 3'b000,
        SRSC_SYNC   = 3'b001,
        SRSC_CLASS  = 3'b011,
        SRSC_WAITHI = 3'b010,
        SRSC_FLASH  = 3'b110,
        SRSC_EXTREL = 3'b111
    } srsc_state_t;
endpackage

// *** rtl/srsc_top.sv ***
// system reset source controller: filter, classification, flags, release sequencing
// Functional notes
// RULE1 - six reset sources; every source except async hardware has its own flag
// RULE2 - mode pin high, pin low beyond long threshold sets long-reset flag
// RULE3 - mode pin high, pin low beyond minimum but within threshold sets short flag
// RULE4 - with bidir enabled, low mode pin stops driving reset pin on soft/watchdog
// RULE5 - input filter rejects spikes under 50ns; 50 to 500ns may pass
// RULE6 - board must hold reset pin low over 500ns for recognition
// RULE7 - reset pin low with mode pin low forces asynchronous reset at once
// RULE8 - async reset drives reset out low, aborts bus, tristates, pulls port zero
// RULE9 - async reset detection needs no running clock
// RULE10 - board keeps reset and mode pins low until clock and port zero settle
// RULE11 - internal flash boot holds internal reset until flash init, at most 1ms; code has no 1ms limit, holds until flashInitDone
// RULE12 - external boot releases internal reset 3 to 8 half-clocks after filter
// RULE13 - flash read before init returns FFFFh first, then 009Bh
// RULE14 - board should prefer synchronous reset to avoid memory corruption
// RULE15 - board never powers device without reset pin grounded
// RULE16 - reset pin low with mode pin high starts synchronous reset
// RULE17 - source flags readable during init, cleared by end-of-init instruction
// RULE18 - filtered reset input is synchronised before classification
`timescale 1ns/1ps
`include "srsc_cfg.svh"
module srsc_top
    import srsc_pkg::*;
(
    // clock and power-on reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // board pins
    input  wire logic        resetInPin,
    input  wire logic        resetModePin,
    input  wire logic        externalAccessPin,
    output logic             resetInPinOut,
    output logic             resetInPinOe,
    output logic             resetOutPin,
    // core events and control
    input  wire logic        bidirResetEnable,
    input  wire logic        watchdogOverflow,
    input  wire logic        softResetInstr,
    input  wire logic        endOfInitInstr,
    input  wire logic        flashInitDone,
    // core-facing reset, bus and flash
    output logic             internalReset,
    output logic             busAbort,
    output logic             ioHighZ,
    output logic             port0PullUp,
    output logic [15:0]      flashEarlyData,
    // source flags
    output logic             powerOnFlag,
    output logic             longHwResetFlag,
    output logic             shortHwResetFlag,
    output logic             watchdogResetFlag,
    output logic             softResetFlag
);
    import srsc_pkg::*;

    // ------------------------------------------------------------
    // asynchronous reset path
    // ------------------------------------------------------------
    // combinational on the raw pins so detection works with no clock;
    // the analog filter in the pad supplies the spike rejection here
    logic asyncRst;
    assign asyncRst = !reset_n || (!resetInPin && !resetModePin); // RULE7 RULE9

    // ------------------------------------------------------------
    // synchroniser and digital filter
    // ------------------------------------------------------------
    logic       sync1_q;
    logic       sync2_q;
    logic       filt_q;
    logic       filt_d;
    logic [3:0] fcnt_q;
    logic [3:0] fcnt_d;
    logic       modeS1_q;
    logic       modeS2_q;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_q  <= 1'b0;
            sync2_q  <= 1'b0;
            modeS1_q <= 1'b0;
            modeS2_q <= 1'b0;
        end
        else
        begin
            sync1_q  <= resetInPin; // RULE18
            sync2_q  <= sync1_q;
            modeS1_q <= resetModePin;
            modeS2_q <= modeS1_q;
        end
    end

    // a level change must persist the minimum spike width before it is taken
    always_comb
    begin
        filt_d = filt_q;
        fcnt_d = 4'h0;
        if (sync2_q != filt_q)
        begin
            if (fcnt_q >= 4'(`SRSC_FILT_CYC - 1))
                filt_d = sync2_q; // RULE5
            else
                fcnt_d = fcnt_q + 4'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            filt_q <= 1'b0;
            fcnt_q <= 4'h0;
        end
        else
        begin
            filt_q <= filt_d;
            fcnt_q <= fcnt_d;
        end
    end

    // ------------------------------------------------------------
    // reset sequencer
    // ------------------------------------------------------------
    // one ref_clk period is two half-clock periods
    localparam int MIN_CYC   = ((`SRSC_MAXPULSE_TCL > `SRSC_MIN4_TCL) ?
                                `SRSC_MAXPULSE_TCL : `SRSC_MIN4_TCL) / 2;
    localparam int LONG_CYC  = `SRSC_SEQ_TCL / 2 + MIN_CYC;
    localparam int EXT_CYC   = `SRSC_EXT_REL_TCL / 2;

    srsc_state_t                 state_q;
    srsc_state_t                 state_d;
    logic [`SRSC_CNT_W-1:0]      cnt_q;
    logic [`SRSC_CNT_W-1:0]      cnt_d;
    logic [`SRSC_CNT_W+5:0]      fcyc_q;
    logic [`SRSC_CNT_W+5:0]      fcyc_d;
    logic                        drivePin_q;
    logic                        drivePin_d;
    logic                        isHw_q;
    logic                        isHw_d;
    logic                        shortSet;
    logic                        longSet;
    logic                        swSet;
    logic                        wdSet;

    always_comb
    begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        fcyc_d     = fcyc_q;
        drivePin_d = drivePin_q;
        isHw_d     = isHw_q;
        shortSet   = 1'b0;
        longSet    = 1'b0;
        swSet      = 1'b0;
        wdSet      = 1'b0;
        case (state_q)
            SRSC_RUN:
            begin
                cnt_d = '0;
                if (!filt_q && modeS2_q)
                begin
                    state_d = SRSC_SYNC; // RULE16
                    isHw_d  = 1'b1;
                end
                else if (watchdogOverflow || softResetInstr)
                begin
                    state_d    = SRSC_WAITHI;
                    isHw_d     = 1'b0;
                    swSet      = softResetInstr;
                    wdSet      = watchdogOverflow && !softResetInstr;
                    drivePin_d = bidirResetEnable && modeS2_q; // RULE4
                end
            end
            SRSC_SYNC:
            begin
                cnt_d = cnt_q + 1'b1;
                if (filt_q)
                begin
                    // pulse ended: short if it reached the minimum width
                    if (cnt_q >= `SRSC_CNT_W'(MIN_CYC))
                    begin
                        shortSet = 1'b1; // RULE3
                        state_d  = SRSC_WAITHI;
                    end
                    else
                        state_d = SRSC_RUN;
                end
                else if (cnt_q >= `SRSC_CNT_W'(LONG_CYC - 1))
                    state_d = SRSC_CLASS;
            end
            SRSC_CLASS:
            begin
                longSet  = 1'b1; // RULE2
                shortSet = 1'b1;
                state_d  = SRSC_WAITHI;
            end
            SRSC_WAITHI:
            begin
                cnt_d = '0;
                // soft/watchdog resets drop the pin drive here; the sequence moves on once it is off and the filtered pin reads high
                if (!isHw_q)
                begin
                    drivePin_d = 1'b0;
                end
                if (filt_q && !drivePin_q)
                begin
                    fcyc_d  = '0;
                    state_d = externalAccessPin ? SRSC_FLASH : SRSC_EXTREL;
                end
            end
            SRSC_FLASH:
            begin
                fcyc_d = fcyc_q + 1'b1;
                if (flashInitDone)
                    state_d = SRSC_RUN; // RULE11
            end
            SRSC_EXTREL:
            begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q >= `SRSC_CNT_W'(EXT_CYC - 1))
                    state_d = SRSC_RUN; // RULE12
            end
            default:
                state_d = SRSC_RUN;
        endcase
    end

    // async reset enters the sequence from scratch regardless of any clock
    always_ff @(posedge ref_clk or posedge asyncRst)
    begin
        if (asyncRst)
        begin
            state_q    <= SRSC_WAITHI;
            cnt_q      <= '0;
            fcyc_q     <= '0;
            drivePin_q <= 1'b0;
            isHw_q     <= 1'b1;
        end
        else
        begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            fcyc_q     <= fcyc_d;
            drivePin_q <= drivePin_d;
            isHw_q     <= isHw_d;
        end
    end

    // ------------------------------------------------------------
    // source flags
    // ------------------------------------------------------------
    logic flagPor_q, flagLong_q, flagShort_q, flagWd_q, flagSw_q;
    logic flagPor_d, flagLong_d, flagShort_d, flagWd_d, flagSw_d;

    // new events win over the end-of-init clear
    always_comb
    begin
        flagPor_d   = flagPor_q   && !endOfInitInstr; // RULE17
        flagLong_d  = (flagLong_q  && !endOfInitInstr) || longSet; // RULE1
        flagShort_d = (flagShort_q && !endOfInitInstr) || shortSet;
        flagWd_d    = (flagWd_q    && !endOfInitInstr) || wdSet;
        flagSw_d    = (flagSw_q    && !endOfInitInstr) || swSet;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flagPor_q   <= 1'b1;
            flagLong_q  <= 1'b0;
            flagShort_q <= 1'b0;
            flagWd_q    <= 1'b0;
            flagSw_q    <= 1'b0;
        end
        else
        begin
            flagPor_q   <= flagPor_d;
            flagLong_q  <= flagLong_d;
            flagShort_q <= flagShort_d;
            flagWd_q    <= flagWd_d;
            flagSw_q    <= flagSw_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic inReset;
    assign inReset = asyncRst || (state_q != SRSC_RUN);

    assign internalReset     = inReset;
    assign resetOutPin       = !inReset; // RULE8
    assign busAbort          = inReset;
    assign ioHighZ           = inReset;
    assign port0PullUp       = asyncRst || (state_q != SRSC_RUN);
    assign resetInPinOut     = 1'b0;
    assign resetInPinOe      = drivePin_q && !asyncRst;
    // flash answers erased at first, then a trapping opcode until ready
    assign flashEarlyData    = (fcyc_q < (`SRSC_CNT_W+6)'(`SRSC_FLASH_FF_CYC)) ?
                               `SRSC_DATA_ERASED : `SRSC_DATA_BUSY; // RULE13
    assign powerOnFlag       = flagPor_q;
    assign longHwResetFlag   = flagLong_q;
    assign shortHwResetFlag  = flagShort_q;
    assign watchdogResetFlag = flagWd_q;
    assign softResetFlag     = flagSw_q;
endmodule

// *** verif/srsc_asserts.sv ***
// assertion checker for the system reset source controller
`timescale 1ns/1ps
module srsc_asserts
(
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        reset_n,
    // board pins
    input wire logic        resetInPin,
    input wire logic        resetModePin,
    input wire logic        externalAccessPin,
    input wire logic        resetInPinOut,
    input wire logic        resetInPinOe,
    input wire logic        resetOutPin,
    // core side
    input wire logic        bidirResetEnable,
    input wire logic        watchdogOverflow,
    input wire logic        softResetInstr,
    input wire logic        endOfInitInstr,
    input wire logic        flashInitDone,
    input wire logic        internalReset,
    input wire logic        busAbort,
    input wire logic        ioHighZ,
    input wire logic [15:0] flashEarlyData,
    input wire logic        longHwResetFlag,
    input wire logic        shortHwResetFlag,
    input wire logic        softResetFlag
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    a_async_forced: assert property ((!resetInPin && !resetModePin)[*4] |-> !resetOutPin)
        else $error("async reset not forced");
    a_bus_follow: assert property (busAbort == internalReset && ioHighZ == internalReset)
        else $error("bus abort or high-z not tied to reset");
    a_out_low: assert property (internalReset |-> !resetOutPin)
        else $error("reset out high during reset");
    a_pin_drive: assert property (resetInPinOe |-> !resetInPinOut && bidirResetEnable)
        else $error("reset pin driven without bidir enable");
    a_long_short: assert property (longHwResetFlag |-> shortHwResetFlag)
        else $error("long flag without short flag");
    a_soft_flag: assert property (softResetInstr && !internalReset |-> ##[1:4] softResetFlag)
        else $error("soft reset flag not set");
    a_eoi_clear: assert property (endOfInitInstr && !internalReset && resetInPin
        && !softResetInstr && !watchdogOverflow |=> !softResetFlag && !shortHwResetFlag)
        else $error("flags not cleared at end of init");
    a_flash_data: assert property (flashEarlyData inside {16'hFFFF, 16'h009B})
        else $error("bad early flash data");
    a_flash_hold: assert property (externalAccessPin && internalReset && !flashInitDone
        |=> internalReset)
        else $error("released before flash init");
    a_ext_release: assert property ((resetInPin && resetModePin && !externalAccessPin
        && !softResetInstr && !watchdogOverflow)[*8] |-> ##[0:20] !internalReset)
        else $error("external boot release late");
    c_long: cover property ($rose(longHwResetFlag));
    c_short: cover property ($rose(shortHwResetFlag));
    c_soft: cover property ($rose(softResetFlag));
endmodule

bind srsc_top srsc_asserts u_srsc_asserts
(
    .ref_clk(ref_clk), .reset_n(reset_n), .resetInPin(resetInPin),
    .resetModePin(resetModePin), .externalAccessPin(externalAccessPin),
    .resetInPinOut(resetInPinOut), .resetInPinOe(resetInPinOe), .resetOutPin(resetOutPin),
    .bidirResetEnable(bidirResetEnable), .watchdogOverflow(watchdogOverflow),
    .softResetInstr(softResetInstr), .endOfInitInstr(endOfInitInstr),
    .flashInitDone(flashInitDone), .internalReset(internalReset), .busAbort(busAbort),
    .ioHighZ(ioHighZ), .flashEarlyData(flashEarlyData), .longHwResetFlag(longHwResetFlag),
    .shortHwResetFlag(shortHwResetFlag), .softResetFlag(softResetFlag)
);

// *** verif/srsc_board.sv ***
// board reset circuitry model driving the reset and mode pins
`timescale 1ns/1ps
module srsc_board
(
    // clock and device side of the reset pin
    input  wire logic ref_clk,
    input  wire logic resetInPinOut,
    input  wire logic resetInPinOe,
    // board pins
    output logic      resetInPin,
    output logic      resetModePin
);
    // powered up with both pins grounded
    logic pinQ = 1'b0;
    logic modeQ = 1'b0;
    // pulled-up wire, low while either party pulls it down
    assign resetInPin = pinQ & ~(resetInPinOe & ~resetInPinOut);
    assign resetModePin = modeQ;
    task automatic drive(input logic pin, input logic mode);
        pinQ <= pin;
        modeQ <= mode;
    endtask
    // callers pick the length; short ones probe the filter on purpose
    task automatic pulse(input int n, input logic mode);
        drive(1'b0, mode);
        repeat (n) @(posedge ref_clk);
        drive(1'b1, mode);
    endtask
endmodule

// *** verif/test_srsc_top.sv ***
// self-checking bench for the system reset source controller
`timescale 1ns/1ps
module test_srsc_top;
    import srsc_pkg::*;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic ea = 1'b0;
    logic bidir = 1'b0;
    logic wdEv = 1'b0;
    logic swEv = 1'b0;
    logic eoiEv = 1'b0;
    logic flDone = 1'b0;
    logic pin, mode, pinOut, pinOe, reset_out_pin, intRst, busAbort, ioHighZ, p0Up;
    logic por, lng, sht, wdg, sft;
    logic [15:0] flData;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    always #12.5 ref_clk = ~ref_clk;
    srsc_board u_srsc_board (.ref_clk(ref_clk), .resetInPinOut(pinOut),
        .resetInPinOe(pinOe), .resetInPin(pin), .resetModePin(mode));
    srsc_top u_srsc_top (.ref_clk(ref_clk), .reset_n(reset_n), .resetInPin(pin),
        .resetModePin(mode), .externalAccessPin(ea), .resetInPinOut(pinOut),
        .resetInPinOe(pinOe), .resetOutPin(reset_out_pin), .bidirResetEnable(bidir),
        .watchdogOverflow(wdEv), .softResetInstr(swEv), .endOfInitInstr(eoiEv),
        .flashInitDone(flDone), .internalReset(intRst), .busAbort(busAbort),
        .ioHighZ(ioHighZ), .port0PullUp(p0Up), .flashEarlyData(flData),
        .powerOnFlag(por), .longHwResetFlag(lng), .shortHwResetFlag(sht),
        .watchdogResetFlag(wdg), .softResetFlag(sft));
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic complete_run();
        if (n_fail == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wait_rel(input int lim);
        for (int i = 0; i < lim && intRst !== 1'b0; i++)
            tick(1);
        chk("internalReset", 16'(intRst), 16'h0000);
    endtask
    task automatic eoi();
        eoiEv <= 1'b1;
        tick(1);
        eoiEv <= 1'b0;
        tick(1);
        chk("all flags", 16'({por, lng, sht, wdg, sft}), 16'h0000);
    endtask
    task automatic hw(input int n, input logic [1:0] exp);
        u_srsc_board.pulse(n, 1'b1);
        tick(10);
        wait_rel(40);
        chk("long short", 16'({lng, sht}), 16'(exp));
        eoi();
    endtask
    task automatic t_async();
        u_srsc_board.drive(1'b0, 1'b0);
        #1;
        chk("async no clock", 16'(reset_out_pin), 16'h0000);
        tick(6);
        chk("async outs", 16'({reset_out_pin, ioHighZ, busAbort, p0Up}), 16'h0007);
        u_srsc_board.drive(1'b1, 1'b1);
        tick(10);
        wait_rel(40);
        chk("async flags", 16'({lng, sht, wdg, sft}), 16'h0000);
    endtask
    task automatic t_event(input logic md, input logic sw);
        logic seen;
        seen = 1'b0;
        bidir <= 1'b1;
        u_srsc_board.drive(1'b1, md);
        tick(3);
        swEv <= sw;
        wdEv <= ~sw;
        tick(1);
        swEv <= 1'b0;
        wdEv <= 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            tick(1);
            if (pinOe === 1'b1)
                seen = 1'b1;
        end
        wait_rel(60);
        chk("pin driven", 16'(seen), 16'(md));
        chk("event flags", 16'({wdg, sft}), sw ? 16'h0001 : 16'h0002);
        bidir <= 1'b0;
        u_srsc_board.drive(1'b1, 1'b1);
        eoi();
    endtask
    task automatic t_flash();
        logic erased;
        erased = 1'b0;
        ea <= 1'b1;
        u_srsc_board.pulse(30, 1'b1);
        for (int i = 0; i < 50; i++)
        begin
            tick(1);
            if (intRst === 1'b1 && flData === 16'hFFFF)
                erased = 1'b1;
        end
        chk("held", 16'(intRst), 16'h0001);
        chk("erased seen", 16'(erased), 16'h0001);
        chk("busy data", flData, 16'h009B);
        flDone <= 1'b1;
        wait_rel(10);
        ea <= 1'b0;
        eoi();
    endtask
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            n_fail++;
            complete_run();
        end
    end
    initial
    begin
        tick(5);
        reset_n <= 1'b1;
        tick(3);
        chk("reset out", 16'(reset_out_pin), 16'h0000);
        u_srsc_board.drive(1'b1, 1'b1);
        wait_rel(40);
        chk("power flag", 16'(por), 16'h0001);
        eoi();
        hw(1, 2'b00);
        hw(10, 2'b00);
        hw(20, 2'b00);
        hw(21, 2'b01);
        hw(30, 2'b01);
        hw(542, 2'b01);
        hw(543, 2'b11);
        hw(600, 2'b11);
        t_async();
        for (int i = 0; i < 4; i++)
            t_event(i[0], i[1]);
        t_flash();
        complete_run();
    end
endmodule
